/* ldc_pkg.sv */
// Shared constants and types of the LED dimming configuration block.
package ldc_pkg;

	// ****************************************************************
	// Register offsets and reset values
	// ****************************************************************
	localparam logic [7:0] LDC_DIMMING_CONFIG_OFS = 8'h40;
	localparam logic [7:0] LDC_PULSE_LIMIT_CONFIG_OFS = 8'h42;
	localparam logic [15:0] LDC_DIMMING_CONFIG_RST = 16'h00B0;
	localparam logic [15:0] LDC_PULSE_LIMIT_CONFIG_RST = 16'h0000;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int LDC_DITHER_HI = 15;
	localparam int LDC_DITHER_LO = 13;
	localparam int LDC_THERMAL_BIT = 9;
	localparam int LDC_RAMP_HI = 7;
	localparam int LDC_RAMP_LO = 5;
	localparam int LDC_SMOOTH_BIT = 4;
	localparam int LDC_METHOD_HI = 1;
	localparam int LDC_METHOD_LO = 0;
	localparam int LDC_SKIP_BIT = 15;

	// ****************************************************************
	// Codes of the brightness source selection and the zero ramp code
	// ****************************************************************
	localparam logic [1:0] LDC_SRC_PWM_INPUT = 2'h0;
	localparam logic [1:0] LDC_SRC_LEVEL_WORD = 2'h2;
	localparam logic [2:0] LDC_RAMP_NONE = 3'h0;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int LDC_CLK_NS = 40;
	localparam int LDC_RAMP_TICK_NS = 1000000;
	localparam int LDC_RAMP_TICK_CYCLES = LDC_RAMP_TICK_NS / LDC_CLK_NS;
	localparam int LDC_MIN_PULSE_NS = 200;
	// Least time, so rounded up; one level equals one clock of width.
	localparam logic [15:0] LDC_MIN_PULSE_LEVEL =
		16'((LDC_MIN_PULSE_NS + LDC_CLK_NS - 1) / LDC_CLK_NS);

	// Full-scale level change per 1 ms tick for each ramp code.
	localparam logic [15:0] LDC_STEP_1MS = 16'hFFFF;
	localparam logic [15:0] LDC_STEP_2MS = 16'h8000;
	localparam logic [15:0] LDC_STEP_50MS = 16'h051F;
	localparam logic [15:0] LDC_STEP_100MS = 16'h0290;
	localparam logic [15:0] LDC_STEP_200MS = 16'h0148;
	localparam logic [15:0] LDC_STEP_300MS = 16'h00DB;
	localparam logic [15:0] LDC_STEP_500MS = 16'h0084;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		LDC_HOLD = 2'b01,
		LDC_RAMP = 2'b10
	} ldc_state_t;

	typedef struct packed {
		ldc_state_t st;
		logic [15:0] cfg1;
		logic [15:0] cfg2;
		logic [15:0] target;
		logic [15:0] applied;
		logic [15:0] rdata;
		logic [23:0] tick_cnt;
		logic tick;
		logic skip;
	} ldc_reg_t;

endpackage

/* ldc_top.sv */
// Dimming configuration registers and brightness ramp engine.
`timescale 1ns/100ps

// How it works
// [R01] A three-bit dither field gives no dither at 0, one to five bits at 1-5.
// [R02] The thermal watch output follows its single control bit, off at reset.
// [R03] A three-bit ramp code selects 0,1,2,50,100,200,300,500 ms, resetting to 5.
// [R04] The smoothed profile moves slower than linear and eases the tail.
// [R05] Software should use the 1 ms and 2 ms codes only with linear ramping.
// [R06] Codes for 50 ms to 500 ms work with both ramp profiles.
// [R07] One bit picks linear (0) or smoothed (1) ramping, smoothed at reset.
// [R08] A two-bit method field picks PWM, 12.5% hybrid or constant current.
// [R09] With the pulse limit set, nonzero levels below a 200 ns width flag a skip.
// [R10] Reserved bits of both words are plain storage resetting to zero.
// [R11] Target comes from the PWM input at source 0 and the level word at 2.
// [R12] Applied brightness ramps to each new target; duration 0 is immediate.
// [R13] Unused dither and method codes are stored as written.
module ldc_top #(
	parameter int TICK_CYCLES = ldc_pkg::LDC_RAMP_TICK_CYCLES
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rstn_i,
	// Register port.
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o,
	// Brightness sources.
	input wire logic [1:0] brightness_src_i,
	input wire logic [15:0] pwm_level_i,
	input wire logic [15:0] display_level_word_i,
	// Settings and state toward the dimming engine.
	output logic [15:0] applied_level_o,
	output logic [2:0] dither_bits_o,
	output logic [1:0] dim_method_o,
	output logic smooth_ramp_on_o,
	output logic thermal_watch_on_o,
	output logic pulse_skip_o,
	output logic ramping_o
);
	import ldc_pkg::*;

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Distance between two levels, used by the ramp and its checks.
	function automatic logic [15:0] ldc_absdiff(input logic [15:0] a,
			input logic [15:0] b);
		ldc_absdiff = (a > b) ? 16'(a - b) : 16'(b - a);
	endfunction

	// Level change per tick for a ramp code in linear mode.
	function automatic logic [15:0] ldc_step(input logic [2:0] code);
		unique case (code)
			3'h1: ldc_step = LDC_STEP_1MS;
			3'h2: ldc_step = LDC_STEP_2MS;
			3'h3: ldc_step = LDC_STEP_50MS;
			3'h4: ldc_step = LDC_STEP_100MS;
			3'h5: ldc_step = LDC_STEP_200MS;
			3'h6: ldc_step = LDC_STEP_300MS;
			3'h7: ldc_step = LDC_STEP_500MS;
			3'h0: ldc_step = 16'hFFFF;
		endcase
	endfunction

	// Step actually taken, halved and tail-eased in smoothed mode.
	function automatic logic [15:0] ldc_eff_step(input logic [2:0] code,
			input logic smooth, input logic [15:0] diff);
		logic [15:0] half;
		logic [15:0] tail;
		half = 16'h0000;
		tail = 16'h0000;
		if (!smooth) begin
			ldc_eff_step = ldc_step(code);
		end else begin
			half = (ldc_step(code) >> 1) | 16'h0001;
			tail = 16'((diff >> 3) + 16'h0001);
			ldc_eff_step = (tail < half) ? tail : half;
		end
	endfunction

	ldc_reg_t q;
	ldc_reg_t next_q;
	logic [15:0] diff;
	logic [15:0] step;

	assign diff = ldc_absdiff(q.applied, q.target);
	assign step = ldc_eff_step(q.cfg1[LDC_RAMP_HI:LDC_RAMP_LO],
		q.cfg1[LDC_SMOOTH_BIT], diff);

	// ****************************************************************
	// Next-state logic
	// ****************************************************************

	// Registers, target selection, ramp and pulse-skip flag.
	always_comb begin
		next_q = q;
		next_q.rdata = 16'h0000;
		// Whole words are stored, so reserved and unused codes keep.
		if (wr_en_i && addr_i == LDC_DIMMING_CONFIG_OFS) begin
			next_q.cfg1 = wdata_i; // [R01] [R03] [R07] [R08] [R10] [R13]
		end
		if (wr_en_i && addr_i == LDC_PULSE_LIMIT_CONFIG_OFS) begin
			next_q.cfg2 = wdata_i; // [R09] [R10]
		end
		if (rd_en_i) begin
			unique case (addr_i)
				LDC_DIMMING_CONFIG_OFS: next_q.rdata = q.cfg1;
				LDC_PULSE_LIMIT_CONFIG_OFS: next_q.rdata = q.cfg2; // [R10]
				default: next_q.rdata = 16'h0000;
			endcase
		end
		// Reserved source codes hold the last target.
		if (brightness_src_i == LDC_SRC_PWM_INPUT) begin
			next_q.target = pwm_level_i; // [R11]
		end else if (brightness_src_i == LDC_SRC_LEVEL_WORD) begin
			next_q.target = display_level_word_i; // [R11]
		end
		// Free-running 1 ms tick paces the ramp.
		if (q.tick_cnt == 24'(TICK_CYCLES - 1)) begin
			next_q.tick_cnt = 24'h000000;
			next_q.tick = 1'b1;
		end else begin
			next_q.tick_cnt = 24'(q.tick_cnt + 24'h000001);
			next_q.tick = 1'b0;
		end
		// Ramp toward the target; code 0 jumps at once.
		if (q.cfg1[LDC_RAMP_HI:LDC_RAMP_LO] == LDC_RAMP_NONE) begin
			next_q.applied = q.target; // [R12] [R03]
			next_q.st = LDC_HOLD;
		end else begin
			unique case (q.st)
				LDC_HOLD: begin
					if (diff != 16'h0000) begin
						next_q.st = LDC_RAMP; // [R12]
					end
				end
				LDC_RAMP: begin
					if (q.tick) begin
						// Smoothed mode uses a smaller step. [R04] [R06]
						if (diff <= step) begin
							next_q.applied = q.target;
							next_q.st = LDC_HOLD;
						end else if (q.applied < q.target) begin
							next_q.applied = 16'(q.applied + step);
						end else begin
							next_q.applied = 16'(q.applied - step);
						end
					end
				end
			endcase
		end
		next_q.skip = q.cfg2[LDC_SKIP_BIT] && q.applied != 16'h0000 &&
			q.applied < LDC_MIN_PULSE_LEVEL; // [R09]
	end

	// ****************************************************************
	// State register
	// ****************************************************************

	// Reset takes only constants, as required for async reset.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '{st: LDC_HOLD, cfg1: LDC_DIMMING_CONFIG_RST,
				cfg2: LDC_PULSE_LIMIT_CONFIG_RST, target: 16'h0000,
				applied: 16'h0000, rdata: 16'h0000, tick_cnt: 24'h000000,
				tick: 1'b0, skip: 1'b0};
		end else begin
			q <= next_q;
		end
	end

	// Outputs straight from the state flops.
	assign rdata_o = q.rdata;
	assign applied_level_o = q.applied;
	assign dither_bits_o = q.cfg1[LDC_DITHER_HI:LDC_DITHER_LO]; // [R01]
	assign dim_method_o = q.cfg1[LDC_METHOD_HI:LDC_METHOD_LO]; // [R08]
	assign smooth_ramp_on_o = q.cfg1[LDC_SMOOTH_BIT]; // [R07]
	assign thermal_watch_on_o = q.cfg1[LDC_THERMAL_BIT]; // [R02]
	assign pulse_skip_o = q.skip;
	assign ramping_o = q.st[1];

	// ****************************************************************
	// Assertions
	// ****************************************************************

	a_dither_store: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R01] [R13]
		wr_en_i && addr_i == LDC_DIMMING_CONFIG_OFS |=>
		dither_bits_o == $past(wdata_i[15:13]))
		else $error("dither field not stored");

	a_thermal_follow: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R02]
		wr_en_i && addr_i == LDC_DIMMING_CONFIG_OFS |=>
		thermal_watch_on_o == $past(wdata_i[9]))
		else $error("thermal watch does not follow its bit");

	a_method_store: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R08] [R13]
		wr_en_i && addr_i == LDC_DIMMING_CONFIG_OFS |=>
		dim_method_o == $past(wdata_i[1:0]) &&
		smooth_ramp_on_o == $past(wdata_i[4]))
		else $error("method or profile not stored");

	a_zero_ramp_jump: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R12] [R03]
		q.cfg1[7:5] == 3'h0 |=> applied_level_o == $past(q.target))
		else $error("zero duration did not apply target at once");

	a_hold_between: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R12]
		q.cfg1[7:5] != 3'h0 && !q.tick |=> $stable(applied_level_o))
		else $error("level moved between ramp ticks");

	a_linear_step: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R03] [R06]
		q.cfg1[7:5] != 3'h0 && !q.cfg1[4] |=>
		ldc_absdiff(applied_level_o, $past(q.applied)) <=
		ldc_step($past(q.cfg1[7:5])))
		else $error("linear ramp step too large");

	a_smooth_slower: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R04] [R07]
		q.cfg1[7:5] != 3'h0 && q.cfg1[4] |=>
		ldc_absdiff(applied_level_o, $past(q.applied)) <=
		((ldc_step($past(q.cfg1[7:5])) >> 1) | 16'h0001))
		else $error("smoothed ramp not slower than linear");

	a_ramp_reaches: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R12]
		q.st == LDC_RAMP && q.tick && diff <= step && q.cfg1[7:5] != 3'h0
		##1 !wr_en_i |-> applied_level_o == $past(q.target))
		else $error("ramp did not land on target");

	a_skip_flag: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R09]
		##1 pulse_skip_o == ($past(q.cfg2[15]) && $past(q.applied) != 16'h0000
		&& $past(q.applied) < 16'h0005))
		else $error("short pulse flag wrong");

	a_reserved_read: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R10]
		wr_en_i && addr_i == LDC_PULSE_LIMIT_CONFIG_OFS ##1
		rd_en_i && addr_i == LDC_PULSE_LIMIT_CONFIG_OFS && !wr_en_i |=>
		rdata_o == $past(wdata_i, 2))
		else $error("pulse limit word not read back");

	a_source_word: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R11]
		brightness_src_i == 2'h2 |=> q.target == $past(display_level_word_i))
		else $error("target not taken from level word");

endmodule // ldc_top

/* ldc_top_tb.sv */
// Self-checking testbench of the LED dimming configuration block.
`timescale 1ns/100ps
module ldc_top_tb;
	import ldc_pkg::*;
	// ****
	// Signals
	// ****
	// A short tick keeps the ramps brief; steps do not depend on it.
	localparam int TICKS = 8;
	localparam int MAX_CYCLES = 20000;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic wr_en_i = 1'b0;
	logic rd_en_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [15:0] wdata_i = 16'h0000;
	logic [1:0] brightness_src_i = 2'h2;
	logic [15:0] pwm_level_i = 16'h0000;
	logic [15:0] display_level_word_i = 16'h0000;
	logic [15:0] rdata_o;
	logic [15:0] applied_level_o;
	logic [2:0] dither_bits_o;
	logic [1:0] dim_method_o;
	logic smooth_ramp_on_o;
	logic thermal_watch_on_o;
	logic pulse_skip_o;
	logic ramping_o;
	int error_cnt = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [15:0] rd_val;
	logic [15:0] prev;
	logic [15:0] w;
	logic [2:0] c;

	ldc_top #(.TICK_CYCLES(TICKS)) DUT (
		.clk_i(clk_i), .rstn_i(rstn_i), .wr_en_i(wr_en_i),
		.rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.rdata_o(rdata_o), .brightness_src_i(brightness_src_i),
		.pwm_level_i(pwm_level_i),
		.display_level_word_i(display_level_word_i),
		.applied_level_o(applied_level_o), .dither_bits_o(dither_bits_o),
		.dim_method_o(dim_method_o), .smooth_ramp_on_o(smooth_ramp_on_o),
		.thermal_watch_on_o(thermal_watch_on_o),
		.pulse_skip_o(pulse_skip_o), .ramping_o(ramping_o));

	// Free-running clock, 40 ns period.
	initial begin
		forever #20 clk_i = ~clk_i;
	end

	// A hung wait must not stall the run, so cycles are capped.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == MAX_CYCLES) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// ****
	// Helpers
	// ****
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_word({15'h0000, got}, {15'h0000, exp});
	endtask

	// Strobes rise and fall at falling edges, one cycle wide.
	task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk_i);
		wr_en_i = 1'b1;
		addr_i = a;
		wdata_i = d;
		@(negedge clk_i);
		wr_en_i = 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk_i);
		rd_en_i = 1'b1;
		addr_i = a;
		@(negedge clk_i);
		rd_en_i = 1'b0;
		d = rdata_o;
	endtask

	// Waits, bounded, until the applied level changes.
	task automatic wait_move();
		prev = applied_level_o;
		for (int i = 0; i < 4 * TICKS && applied_level_o === prev; i++)
			@(negedge clk_i);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ****
	// Scenarios
	// ****
	task automatic test_reset();
		reg_rd(LDC_DIMMING_CONFIG_OFS, rd_val);
		chk_word(rd_val, 16'h00B0);
		reg_rd(LDC_PULSE_LIMIT_CONFIG_OFS, rd_val);
		chk_word(rd_val, 16'h0000);
		chk_bit(smooth_ramp_on_o, 1'b1);
		chk_bit(thermal_watch_on_o, 1'b0);
		chk_word({13'h0000, dither_bits_o}, 16'h0000);
		chk_word({14'h0000, dim_method_o}, 16'h0000);
		$display("reset test done");
	endtask

	// Every dither and method code, both profiles, reserved bits 12, 10 and 2 set.
	task automatic test_fields();
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			// Ramp codes 1 and 2 come with linear ramping only.
			w = {c, 3'h5, c[0], c[1], c, c[2], 2'h1, c[1:0]};
			reg_wr(LDC_DIMMING_CONFIG_OFS, w);
			reg_rd(LDC_DIMMING_CONFIG_OFS, rd_val);
			chk_word(rd_val, w);
			chk_word({13'h0000, dither_bits_o}, {13'h0000, c});
			chk_word({14'h0000, dim_method_o}, {14'h0000, c[1:0]});
			chk_bit(thermal_watch_on_o, c[0]);
			chk_bit(smooth_ramp_on_o, c[2]);
		end
		reg_wr(LDC_PULSE_LIMIT_CONFIG_OFS, 16'hFFFF);
		reg_wr(8'h44, 16'h0000);
		reg_rd(8'h44, rd_val);
		chk_word(rd_val, 16'h0000);
		reg_rd(LDC_PULSE_LIMIT_CONFIG_OFS, rd_val);
		chk_word(rd_val, 16'hFFFF);
		// Read data stands for one cycle only, then falls back to zero.
		@(negedge clk_i);
		chk_word(rdata_o, 16'h0000);
		reg_wr(LDC_PULSE_LIMIT_CONFIG_OFS, 16'h0000);
		$display("field test done");
	endtask

	// Zero ramp code, both sources, and the short-pulse flag.
	task automatic test_direct();
		reg_wr(LDC_DIMMING_CONFIG_OFS, 16'h0000);
		display_level_word_i = 16'h1234;
		repeat (3) @(negedge clk_i);
		chk_word(applied_level_o, 16'h1234);
		brightness_src_i = 2'h0;
		pwm_level_i = 16'h0003;
		repeat (3) @(negedge clk_i);
		chk_word(applied_level_o, 16'h0003);
		chk_bit(pulse_skip_o, 1'b0);
		reg_wr(LDC_PULSE_LIMIT_CONFIG_OFS, 16'h8000);
		repeat (3) @(negedge clk_i);
		chk_bit(pulse_skip_o, 1'b1);
		pwm_level_i = 16'h0005;
		repeat (4) @(negedge clk_i);
		chk_bit(pulse_skip_o, 1'b0);
		reg_wr(LDC_PULSE_LIMIT_CONFIG_OFS, 16'h0000);
		pwm_level_i = 16'h0000;
		repeat (3) @(negedge clk_i);
		$display("direct test done");
	endtask

	// 200 ms linear then smoothed; smoothed steps are smaller.
	task automatic test_ramps();
		reg_wr(LDC_DIMMING_CONFIG_OFS, 16'h00A0);
		pwm_level_i = 16'h0290;
		repeat (2) @(negedge clk_i);
		chk_bit(ramping_o, 1'b1);
		wait_move();
		chk_word(applied_level_o, 16'h0148);
		wait_move();
		chk_word(applied_level_o, 16'h0290);
		repeat (2) @(negedge clk_i);
		chk_bit(ramping_o, 1'b0);
		reg_wr(LDC_DIMMING_CONFIG_OFS, 16'h00B0);
		pwm_level_i = 16'h1290;
		wait_move();
		chk_word(applied_level_o, 16'h0335);
		$display("ramp test done");
	endtask

	// 1 ms and 2 ms codes, linear only, land within a single tick.
	task automatic test_fast();
		pwm_level_i = 16'h8000;
		reg_wr(LDC_DIMMING_CONFIG_OFS, 16'h0020);
		wait_move();
		chk_word(applied_level_o, 16'h8000);
		repeat (2) @(negedge clk_i);
		chk_bit(ramping_o, 1'b0);
		reg_wr(LDC_DIMMING_CONFIG_OFS, 16'h0040);
		pwm_level_i = 16'h0000;
		wait_move();
		chk_word(applied_level_o, 16'h0000);
		$display("fast ramp test done");
	endtask

	// Main sequence.
	initial begin
		repeat (10) @(negedge clk_i);
		rstn_i = 1'b1;
		test_reset();
		test_fields();
		test_direct();
		test_ramps();
		test_fast();
		tally_and_finish();
	end
endmodule // ldc_top_tb
